// ===== pwm_switch_pkg.sv
// Purpose: shared constants of the six-channel switch pwm block
// Assumes: 16-bit serial frames with a 4-bit register address on top
// Notes:   offsets, field positions, reset values and timing counts live here only
package pwm_switch_pkg;

    // channel counts
    localparam int CHANNELS     = 6;     // five internal outputs plus one external
    localparam int INT_CHANNELS = 5;     // channels reached by the step register
    localparam int INPUTS       = 4;     // direct control inputs

    // register addresses carried in frame bits 15..12
    localparam logic [3:0] ADDR_INIT     = 4'h1;
    localparam logic [3:0] ADDR_CH_FIRST = 4'h2;
    localparam logic [3:0] ADDR_CH_LAST  = 4'h7;
    localparam logic [3:0] ADDR_OUT_CTRL = 4'h8;
    localparam logic [3:0] ADDR_GLOBAL   = 4'h9;
    localparam logic [3:0] ADDR_IN_EN    = 4'hb;
    localparam logic [3:0] ADDR_PRESCALE = 4'hc;
    localparam logic [3:0] ADDR_STEP     = 4'he;

    // field positions inside a frame
    localparam int ADDR_MSB     = 15;
    localparam int ADDR_LSB     = 12;
    localparam int SUB_SEL_BIT  = 11;    // picks the half of a split register
    localparam int PHASE_MSB    = 10;
    localparam int PHASE_LSB    = 9;
    localparam int ON_BIT       = 8;
    localparam int DUTY_MSB     = 7;
    localparam int SYNC_BIT     = 1;
    localparam int STEP_DIR_BIT = 10;

    // reset values
    localparam logic [7:0] DUTY_RST  = 8'h00;
    localparam logic [5:0] ON_RST    = 6'h00;
    localparam logic [5:0] GSEL_RST  = 6'h00;  // individual duty by default
    localparam logic [7:0] IEN_RST   = 8'h00;
    localparam logic [1:0] PRES_RST  = 2'h0;
    localparam logic [1:0] PHASE_RST = 2'h0;

    // duty values and usable ranges
    localparam logic [7:0] DUTY_FULL     = 8'hff;
    localparam logic [7:0] DUTY_ZERO     = 8'h00;
    localparam logic [7:0] DUTY_MIN_DIV4 = 8'h03;
    localparam logic [7:0] DUTY_MAX_DIV4 = 8'hfb;
    localparam logic [7:0] DUTY_MIN_FAST = 8'h07;
    localparam logic [7:0] DUTY_MAX_FAST = 8'hf7;

    // prescale and step codes
    localparam logic [1:0] PRS_DIV4  = 2'h0;
    localparam logic [1:0] PRS_DIV2  = 2'h1;
    localparam logic [1:0] PRE_LAST  = 2'h3;
    localparam logic [7:0] STEP_S4   = 8'h04;
    localparam logic [7:0] STEP_S8   = 8'h08;
    localparam logic [7:0] STEP_S16  = 8'h10;

    // reference clock window, in hertz, and the derived cycle counts
    localparam int SYS_HZ     = 25000000;
    localparam int REF_MIN_HZ = 25600;
    localparam int REF_MAX_HZ = 102400;
    localparam logic [9:0] REF_LONG_CYC  = 10'(SYS_HZ / REF_MIN_HZ);
    localparam logic [9:0] REF_SHORT_CYC = 10'((SYS_HZ + REF_MAX_HZ - 1) / REF_MAX_HZ);
    localparam logic [9:0] PER_SAT       = 10'h3ff;

endpackage

// ===== multi_channel_switch_pwm.sv
// Purpose: pwm generation for six switch channels, programmed by 16-bit serial frames
// Assumes: spi_clk stands still outside frames; data sampled on its falling edge
// Notes:   all settings commit on the synchronised rising edge of select_bar
//
// Behaviour
// - pwm timing from reference clock, 256 steps
// - prescale 00 div4, 01 div2, 1x div1
// - reference clock failure drives enabled outputs full-on
// - channel frame: address, phase, on, duty
// - on bits mirrored in output control register
// - off, full duty, phase, prescale apply immediately
// - sub-full duty applies at next period start
// - duty changes via duty, global select, step
// - sync bit resets all pwm counters
// - no pulsing in fail mode or clock fail
// - global select bit picks shared duty
// - shared duty from global value register
// - input enable gates or inverts duty choice
// - global channels keep own phase and prescale
// - step frame touches only five internal duties
// - shared sign, per-channel step 0/4/8/16
// - step saturates at 00 and ff
// - duty clamped to usable range per prescale
// - outputs register once, no duty skew
`timescale 1ns/1ps
module multi_channel_switch_pwm (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       spi_clk,
    input  wire logic       select_bar,
    input  wire logic       data_in,
    input  wire logic       ref_clock,
    input  wire logic [3:0] direct_control_input,
    input  wire logic       fail_mode,
    output logic      [5:0] switch_outputs
);

    // whole system-domain state in one record
    typedef struct packed {
        logic            ref_s1;    // reference clock sync stage one
        logic            ref_s2;    // reference clock sync stage two
        logic            ref_s3;    // edge detect history
        logic            csb_s1;    // select_bar sync stage one
        logic            csb_s2;    // select_bar sync stage two
        logic            csb_s3;    // edge detect history
        logic [3:0]      in_s1;     // direct input sync stage one
        logic [3:0]      in_s2;     // direct input sync stage two
        logic            fail_s1;   // fail mode sync stage one
        logic            fail_s2;   // fail mode sync stage two
        logic [9:0]      per;       // cycles since last reference edge
        logic            clk_fail;  // reference clock out of window
        logic [1:0]      pre_cnt;   // shared prescale divider
        logic [5:0]      on_bits;   // channel on bits
        logic [5:0]      gsel;      // shared duty assignment bits
        logic [7:0]      gduty;     // shared duty value
        logic [3:0][1:0] ien;       // input enable pairs, high bit first
        logic [5:0][1:0] phase;     // phase select per channel
        logic [5:0][1:0] pres;      // prescale select per channel
        logic [5:0][7:0] duty;      // individual duty values
        logic [5:0][7:0] cnt;       // period counters
        logic [5:0]      act_on;    // channel running
        logic [5:0][7:0] act_duty;  // duty in force this period
        logic [5:0]      out;       // registered switch outputs
    } state_t;

    state_t st;       // current state
    state_t next_st;  // next state

    logic [15:0] frame;             // link-domain shift register
    logic        tick;              // one reference edge
    logic        commit;            // frame ended
    logic [3:0]  addr;              // register address of the frame
    logic [5:0]  want_on;           // channel state after gating
    logic [5:0]  adv;               // counter advances this cycle
    logic [5:0]  start;             // period begins on next count
    logic [5:0][7:0] want_duty;     // effective, clamped duty
    logic [5:0][7:0] pos;           // phase-shifted count
    logic [5:0][1:0] ien_w;         // input enables widened to all channels
    logic [5:0]      in_w;          // inputs widened to all channels

    // link side: shift in on falling clock, msb first
    // the word is only read while select_bar is high, when the link clock is
    // stopped and the word stands still, so it crosses qualified by the synced level
    always_ff @(negedge spi_clk) begin
        frame <= {frame[14:0], data_in};
    end

    assign tick   = st.ref_s2 & ~st.ref_s3;
    assign commit = st.csb_s2 & ~st.csb_s3;
    assign addr   = frame[pwm_switch_pkg::ADDR_MSB:pwm_switch_pkg::ADDR_LSB];
    assign ien_w  = {4'h0, st.ien};
    assign in_w   = {2'h0, st.in_s2};

    // saturating step of one duty value
    function automatic logic [7:0] step_duty(input logic [7:0] d, input logic [1:0] code, input logic up);
        logic [7:0] amt;
        logic [8:0] sum;
        begin
            case (code)
                2'h1:    amt = pwm_switch_pkg::STEP_S4;
                2'h2:    amt = pwm_switch_pkg::STEP_S8;
                2'h3:    amt = pwm_switch_pkg::STEP_S16;
                default: amt = 8'h00;
            endcase
            sum = {1'b0, d} + {1'b0, amt};
            if (up) begin
                step_duty = sum[8] ? pwm_switch_pkg::DUTY_FULL : sum[7:0];
            end else begin
                step_duty = (d < amt) ? pwm_switch_pkg::DUTY_ZERO : 8'(d - amt);
            end
        end
    endfunction

    // per-channel gating, duty choice and counter position
    genvar gi;
    generate
        for (gi = 0; gi < pwm_switch_pkg::CHANNELS; gi++) begin : g_ch
            logic       sel_g;
            logic [7:0] raw;
            logic [7:0] lo;
            logic [7:0] hi;
            // input pair 11 with input high swaps the duty source
            assign sel_g = st.gsel[gi] ^ ((ien_w[gi] == 2'h3) & in_w[gi]);
            assign raw   = sel_g ? st.gduty : st.duty[gi];
            // div2 and div1 need wider margins at the rails than div4
            assign lo    = (st.pres[gi] == pwm_switch_pkg::PRS_DIV4) ? pwm_switch_pkg::DUTY_MIN_DIV4
                                                                     : pwm_switch_pkg::DUTY_MIN_FAST;
            assign hi    = (st.pres[gi] == pwm_switch_pkg::PRS_DIV4) ? pwm_switch_pkg::DUTY_MAX_DIV4
                                                                     : pwm_switch_pkg::DUTY_MAX_FAST;
            // full duty bypasses the clamp so continuous on stays possible
            assign want_duty[gi] = (raw == pwm_switch_pkg::DUTY_FULL) ? raw :
                                   (raw < lo) ? lo : (raw > hi) ? hi : raw;
            // 00 keeps on, 01 or 10 gate with the input, 11 keeps on
            assign want_on[gi] = st.on_bits[gi] &
                                 ((ien_w[gi] == 2'h0) | (ien_w[gi] == 2'h3) | in_w[gi]);
            // own prescale even when on the shared duty
            assign adv[gi] = tick & (st.pres[gi][1] |
                             ((st.pres[gi] == pwm_switch_pkg::PRS_DIV2) & st.pre_cnt[0]) |
                             ((st.pres[gi] == pwm_switch_pkg::PRS_DIV4) &
                              (st.pre_cnt == pwm_switch_pkg::PRE_LAST)));
            // phase select shifts the period by quarters
            assign pos[gi]   = st.cnt[gi] + {st.phase[gi], 6'h00};
            assign start[gi] = adv[gi] & (pos[gi] == pwm_switch_pkg::DUTY_FULL);
        end
    endgenerate

    // next-state logic
    always_comb begin
        next_st = st;
        // two-stage synchronisers; stage one feeds only stage two
        next_st.ref_s1  = ref_clock;
        next_st.ref_s2  = st.ref_s1;
        next_st.ref_s3  = st.ref_s2;
        next_st.csb_s1  = select_bar;
        next_st.csb_s2  = st.csb_s1;
        next_st.csb_s3  = st.csb_s2;
        next_st.in_s1   = direct_control_input;
        next_st.in_s2   = st.in_s1;
        next_st.fail_s1 = fail_mode;
        next_st.fail_s2 = st.fail_s1;

        // reference period check, judged at each edge and on overrun
        if (tick) begin
            next_st.per      = 10'h001;
            next_st.clk_fail = (st.per < pwm_switch_pkg::REF_SHORT_CYC) |
                               (st.per > pwm_switch_pkg::REF_LONG_CYC);
        end else begin
            if (st.per != pwm_switch_pkg::PER_SAT) begin
                next_st.per = st.per + 10'h001;
            end
            if (st.per > pwm_switch_pkg::REF_LONG_CYC) begin
                next_st.clk_fail = 1'b1;
            end
        end

        // shared divider feeding the div2 and div4 prescale selects; div1 ignores it
        if (tick) begin
            next_st.pre_cnt = st.pre_cnt + 2'h1;
        end

        // channel counters, duty hand-over and outputs
        for (int i = 0; i < pwm_switch_pkg::CHANNELS; i++) begin
            if (adv[i]) begin
                next_st.cnt[i] = st.cnt[i] + 8'h01;
            end
            if (!want_on[i]) begin
                next_st.act_on[i] = 1'b0;
            end else if (want_duty[i] == pwm_switch_pkg::DUTY_FULL) begin
                // full duty cannot glitch, so it needs no period boundary
                next_st.act_on[i]   = 1'b1;
                next_st.act_duty[i] = pwm_switch_pkg::DUTY_FULL;
            end else if (start[i]) begin
                // partial duty waits for the boundary to avoid a runt pulse
                next_st.act_on[i]   = 1'b1;
                next_st.act_duty[i] = want_duty[i];
            end
            // one flop from decision to pin keeps rise and fall paths equal
            if (st.clk_fail | st.fail_s2) begin
                next_st.out[i] = want_on[i];
            end else begin
                next_st.out[i] = st.act_on[i] & (pos[i] <= st.act_duty[i]);
            end
        end

        // frame decode at the end of the frame
        if (commit) begin
            case (addr)
                pwm_switch_pkg::ADDR_INIT: begin
                    // clear bit does nothing
                    if (frame[pwm_switch_pkg::SYNC_BIT]) begin
                        next_st.pre_cnt = 2'h0;
                        next_st.cnt     = '0;
                    end
                end
                pwm_switch_pkg::ADDR_OUT_CTRL: begin
                    next_st.on_bits = frame[5:0];
                end
                pwm_switch_pkg::ADDR_GLOBAL: begin
                    if (frame[pwm_switch_pkg::SUB_SEL_BIT]) begin
                        next_st.gduty = frame[pwm_switch_pkg::DUTY_MSB:0];
                    end else begin
                        next_st.gsel = frame[5:0];
                    end
                end
                pwm_switch_pkg::ADDR_IN_EN: begin
                    next_st.ien = frame[7:0];
                end
                pwm_switch_pkg::ADDR_PRESCALE: begin
                    // takes effect at once; host must have the channel off
                    if (frame[pwm_switch_pkg::SUB_SEL_BIT]) begin
                        next_st.pres[5:4] = frame[3:0];
                    end else begin
                        next_st.pres[3:0] = frame[7:0];
                    end
                end
                pwm_switch_pkg::ADDR_STEP: begin
                    // the sixth channel and the shared duty are left alone
                    for (int k = 0; k < pwm_switch_pkg::INT_CHANNELS; k++) begin
                        next_st.duty[k] = step_duty(st.duty[k], frame[2*k +: 2],
                                                    frame[pwm_switch_pkg::STEP_DIR_BIT]);
                    end
                end
                default: begin
                    // channel registers 2..7, other addresses ignored
                    if (addr >= pwm_switch_pkg::ADDR_CH_FIRST && addr <= pwm_switch_pkg::ADDR_CH_LAST) begin
                        for (int c = 0; c < pwm_switch_pkg::CHANNELS; c++) begin
                            if (addr == 4'(c + 2)) begin
                                next_st.phase[c]   = frame[pwm_switch_pkg::PHASE_MSB:pwm_switch_pkg::PHASE_LSB];
                                next_st.on_bits[c] = frame[pwm_switch_pkg::ON_BIT];
                                next_st.duty[c]    = frame[pwm_switch_pkg::DUTY_MSB:0];
                            end
                        end
                    end
                end
            endcase
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st          <= '0;
            st.ref_s1   <= 1'b0;
            st.csb_s1   <= 1'b1;  // idle high, no false commit
            st.csb_s2   <= 1'b1;
            st.csb_s3   <= 1'b1;
            st.clk_fail <= 1'b1;  // no reference seen yet
            st.on_bits  <= pwm_switch_pkg::ON_RST;
            st.gsel     <= pwm_switch_pkg::GSEL_RST;
            st.ien      <= pwm_switch_pkg::IEN_RST;
            st.pres     <= {pwm_switch_pkg::CHANNELS{pwm_switch_pkg::PRES_RST}};
            st.phase    <= {pwm_switch_pkg::CHANNELS{pwm_switch_pkg::PHASE_RST}};
            st.duty     <= {pwm_switch_pkg::CHANNELS{pwm_switch_pkg::DUTY_RST}};
        end else begin
            st <= next_st;
        end
    end

    assign switch_outputs = st.out;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_clk_fail_full;
        st.clk_fail |=> (st.out == $past(want_on));
    endproperty
    a_clk_fail_full: assert property (p_clk_fail_full) else $error("clock fail not full on");

    property p_fail_mode_steady;
        (st.fail_s2 && !st.clk_fail) |=> (st.out == $past(want_on));
    endproperty
    a_fail_mode_steady: assert property (p_fail_mode_steady) else $error("pulsing in fail mode");

    property p_sync_reset;
        (commit && addr == pwm_switch_pkg::ADDR_INIT && frame[pwm_switch_pkg::SYNC_BIT])
            |=> (st.pre_cnt == 2'h0 && st.cnt == '0);
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("counters not reset by sync");

    sequence s_off_frame;
        commit && addr == pwm_switch_pkg::ADDR_CH_FIRST && !frame[pwm_switch_pkg::ON_BIT];
    endsequence
    sequence s_off_done;
        !st.on_bits[0] ##1 !st.act_on[0];
    endsequence
    property p_turn_off;
        s_off_frame |=> s_off_done;
    endproperty
    a_turn_off: assert property (p_turn_off) else $error("turn off not immediate");

    property p_duty_boundary;
        (st.act_duty[0] != $past(st.act_duty[0])) |->
            ($past(start[0]) || st.act_duty[0] == pwm_switch_pkg::DUTY_FULL);
    endproperty
    a_duty_boundary: assert property (p_duty_boundary) else $error("duty changed mid period");

    property p_step_saturate;
        (commit && addr == pwm_switch_pkg::ADDR_STEP && frame[pwm_switch_pkg::STEP_DIR_BIT] &&
         frame[1:0] == 2'h3 && st.duty[0] >= 8'hf0) |=> (st.duty[0] == pwm_switch_pkg::DUTY_FULL);
    endproperty
    a_step_saturate: assert property (p_step_saturate) else $error("step did not saturate");

    property p_step_scope;
        (commit && addr == pwm_switch_pkg::ADDR_STEP) |=>
            (st.duty[5] == $past(st.duty[5]) && st.gduty == $past(st.gduty));
    endproperty
    a_step_scope: assert property (p_step_scope) else $error("step touched external or shared duty");

    property p_shared_select;
        (st.ien[0] == 2'h0 && st.gsel[0] && st.gduty == 8'h80) |-> (want_duty[0] == 8'h80);
    endproperty
    a_shared_select: assert property (p_shared_select) else $error("shared duty not used");

    property p_input_gate;
        (st.ien[0] == 2'h1 && !st.in_s2[0]) |-> !want_on[0];
    endproperty
    a_input_gate: assert property (p_input_gate) else $error("input did not gate channel");

    property p_full_on;
        // fail paths follow the gated on bit instead, so they are left out here
        (st.act_on[0] && st.act_duty[0] == pwm_switch_pkg::DUTY_FULL && !st.clk_fail && !st.fail_s2) [*2]
            |=> st.out[0];
    endproperty
    a_full_on: assert property (p_full_on) else $error("full duty not continuous");

    property p_div4_hold;
        (tick && st.pres[0] == pwm_switch_pkg::PRS_DIV4 && st.pre_cnt != pwm_switch_pkg::PRE_LAST && !commit)
            |=> (st.cnt[0] == $past(st.cnt[0]));
    endproperty
    a_div4_hold: assert property (p_div4_hold) else $error("divide by four advanced early");

    // a running partial duty always lies inside the widest usable window
    property p_duty_window;
        (st.act_on[0] && st.act_duty[0] != pwm_switch_pkg::DUTY_FULL) |->
            (st.act_duty[0] >= pwm_switch_pkg::DUTY_MIN_DIV4 && st.act_duty[0] <= pwm_switch_pkg::DUTY_MAX_DIV4);
    endproperty
    a_duty_window: assert property (p_duty_window) else $error("partial duty outside usable range");

    // output control frame rewrites every on bit at once
    property p_on_mirror;
        (commit && addr == pwm_switch_pkg::ADDR_OUT_CTRL) |=> (st.on_bits == $past(frame[5:0]));
    endproperty
    a_on_mirror: assert property (p_on_mirror) else $error("output control did not set on bits");

    // shared duty half of the global register lands in the shared value
    property p_shared_write;
        (commit && addr == pwm_switch_pkg::ADDR_GLOBAL && frame[pwm_switch_pkg::SUB_SEL_BIT])
            |=> (st.gduty == $past(frame[pwm_switch_pkg::DUTY_MSB:0]));
    endproperty
    a_shared_write: assert property (p_shared_write) else $error("shared duty not stored");

endmodule

// ===== host_spi_model.sv
// Purpose: host model that sends 16-bit serial frames into the pwm block
// Assumes: link clock idles low and runs only inside frames, 30 ns period
// Notes:   data moves after each falling edge, so it is stable when the device samples
`timescale 1ns/1ps
module host_spi_model (
    output logic spi_clk,
    output logic select_bar,
    output logic data_in
);
    // idle: deselected, link clock parked low
    initial begin
        spi_clk    = 1'b0;
        select_bar = 1'b1;
        data_in    = 1'b0;
    end

    // one whole frame, msb first; the gap after it keeps frames apart
    task automatic send(input logic [15:0] frame);
        int i;
        #7 select_bar = 1'b0;
        #320;
        for (i = 15; i >= 0; i--) begin
            #5 data_in = frame[i];
            #10 spi_clk = 1'b1;
            #15 spi_clk = 1'b0;
        end
        #100 select_bar = 1'b1;
        data_in = ~frame[0];  // released line must not keep the last bit
        #1000;
    endtask
endmodule

// ===== multi_channel_switch_pwm_tb_top.sv
// Purpose: self-checking bench of the six-channel switch pwm block
// Assumes: host model sends frames; channels are only switched off before timing changes
// Notes:   duty pulsing is timed only at the div1 phase 3 start after sync; steady states (full duty, clock fail, fail mode) are
`timescale 1ns/1ps
module multi_channel_switch_pwm_tb_top;
    logic       clk_sys;               // system clock, 25 MHz
    logic       rst_b;                 // synchronous reset, active low
    logic       spi_clk;               // link clock from the host model
    logic       select_bar;            // frame select from the host model
    logic       data_in;               // serial data from the host model
    logic       ref_clock;             // pwm reference clock
    logic       ref_run;               // lets the reference clock toggle
    logic [7:0] ref_cnt;               // half period counter
    logic [3:0] direct_control_input;  // direct inputs of channels 0..3
    logic       fail_mode;             // fail mode request
    logic [5:0] switch_outputs;        // channel outputs
    logic [5:0] exp_q [$];             // expected outputs, oldest first
    logic [7:0] lfsr;                  // random source
    logic [5:0] on_mask;               // on bits the bench has written
    logic [3:0] gate;                  // expected input gating of channels 0..3
    int         failures;
    int         total_checks;
    int         ch;
    event       sample_now;

    multi_channel_switch_pwm u_dut (
        .clk_sys              (clk_sys),
        .rst_b                (rst_b),
        .spi_clk              (spi_clk),
        .select_bar           (select_bar),
        .data_in              (data_in),
        .ref_clock            (ref_clock),
        .direct_control_input (direct_control_input),
        .fail_mode            (fail_mode),
        .switch_outputs       (switch_outputs)
    );

    host_spi_model u_host (
        .spi_clk    (spi_clk),
        .select_bar (select_bar),
        .data_in    (data_in)
    );

    // system clock
    always #20 clk_sys = ~clk_sys;

    // reference at 312 cycles a period, inside the accepted window
    always @(posedge clk_sys) begin
        ref_cnt <= (ref_cnt == 8'h9b) ? 8'h00 : ref_cnt + 8'h01;
        if (ref_run && ref_cnt == 8'h9b) begin
            ref_clock <= ~ref_clock;
        end
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic check(input logic [5:0] seen, input logic [5:0] want);
        total_checks++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %0t outputs %h expected %h", $time, seen, want);
        end
    endtask

    // note the expectation, then let the watcher sample once it has settled
    task automatic expect_out(input logic [5:0] want);
        exp_q.push_back(want);
        repeat (12) @(posedge clk_sys);
        -> sample_now;
    endtask

    // watcher: one step after the edge so the edge's updates have landed
    always @(sample_now) begin
        #1;
        check(switch_outputs, exp_q.pop_front());
    end

    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog, far beyond the expected run
    initial begin
        #(40 * 60000);
        failures++;
        wrap_up();
    end

    initial begin
        clk_sys = 1'b0; rst_b = 1'b0; ref_clock = 1'b0; ref_run = 1'b0; ref_cnt = 8'h00;
        direct_control_input = 4'h0; fail_mode = 1'b0; lfsr = 8'h2d; on_mask = 6'h00;
        failures = 0; total_checks = 0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        expect_out(6'h00);
        // reference stopped: clock fail, enabled outputs full on
        for (ch = 0; ch < 6; ch++) begin
            lfsr = lfsr_next(lfsr);
            u_host.send({4'(pwm_switch_pkg::ADDR_CH_FIRST + ch), 4'h1, lfsr});
            on_mask[ch] = 1'b1;
            expect_out(on_mask);
        end
        $display("test channel frames done");
        // mirror of the on bits, written from both registers
        lfsr = lfsr_next(lfsr);
        u_host.send({pwm_switch_pkg::ADDR_OUT_CTRL, 6'h00, lfsr[5:0] | 6'h04});
        expect_out(lfsr[5:0] | 6'h04);
        u_host.send({4'(pwm_switch_pkg::ADDR_CH_FIRST + 2), 4'h0, 8'h80});
        expect_out(lfsr[5:0] & 6'h3b);
        $display("test on mirror done");
        // input enable codes on channels 0..3 with random inputs
        u_host.send({pwm_switch_pkg::ADDR_OUT_CTRL, 12'h03f});
        for (ch = 0; ch < 4; ch++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk_sys);
            direct_control_input <= lfsr[3:0];
            u_host.send({pwm_switch_pkg::ADDR_IN_EN, 4'h0, {4{2'(ch)}}});
            gate = (ch == 1 || ch == 2) ? lfsr[3:0] : 4'hf;
            expect_out({2'b11, gate});
        end
        u_host.send({pwm_switch_pkg::ADDR_IN_EN, 12'h000});
        $display("test input enable done");
        // reference running: full duty stays on, off is immediate
        ref_run <= 1'b1;
        u_host.send({pwm_switch_pkg::ADDR_OUT_CTRL, 12'h000});
        repeat (1200) @(posedge clk_sys);
        u_host.send({pwm_switch_pkg::ADDR_CH_FIRST, 4'h1, pwm_switch_pkg::DUTY_FULL});
        for (ch = 0; ch < 4; ch++) begin
            expect_out(6'h01);
            repeat (150) @(posedge clk_sys);
        end
        u_host.send({4'h0, 12'hfff});
        expect_out(6'h01);
        u_host.send({pwm_switch_pkg::ADDR_INIT, 12'h002});
        expect_out(6'h01);
        u_host.send({pwm_switch_pkg::ADDR_OUT_CTRL, 12'h000});
        expect_out(6'h00);
        $display("test running reference done");
        // shared full duty turns a channel on at once; its own duty would wait
        u_host.send({pwm_switch_pkg::ADDR_GLOBAL, 4'h8, pwm_switch_pkg::DUTY_FULL});
        u_host.send({pwm_switch_pkg::ADDR_GLOBAL, 12'h005});
        u_host.send({4'(pwm_switch_pkg::ADDR_CH_FIRST + 2), 4'h1, 8'h40});
        expect_out(6'h04);
        u_host.send({pwm_switch_pkg::ADDR_GLOBAL, 4'h8, 8'h80});
        u_host.send({pwm_switch_pkg::ADDR_STEP, 2'h1, 10'h003});
        expect_out(6'h04);
        // div1 with phase 3 starts 64 ticks after the sync; div2 or div4 not yet
        u_host.send({pwm_switch_pkg::ADDR_OUT_CTRL, 12'h000});
        u_host.send({pwm_switch_pkg::ADDR_PRESCALE, 12'h0ff});
        u_host.send({pwm_switch_pkg::ADDR_CH_FIRST, 4'h7, 8'h80});
        expect_out(6'h00);
        u_host.send({pwm_switch_pkg::ADDR_INIT, 12'h002});
        repeat (24000) @(posedge clk_sys);
        expect_out(6'h01);
        u_host.send({pwm_switch_pkg::ADDR_CH_FIRST, 12'h000});
        expect_out(6'h00);
        $display("test shared duty and prescale done");
        // fail mode: a sub-full duty channel no longer pulses
        @(posedge clk_sys);
        fail_mode <= 1'b1;
        u_host.send({4'(pwm_switch_pkg::ADDR_CH_FIRST + 1), 4'h1, 8'h80});
        for (ch = 0; ch < 4; ch++) begin
            expect_out(6'h02);
            repeat (200) @(posedge clk_sys);
        end
        $display("test fail mode done");
        wrap_up();
    end
endmodule
